// ===== rgc_defines.svh
// offsets, field positions, reset values and timing counts of the global command block
`ifndef RGC_DEFINES_SVH
`define RGC_DEFINES_SVH
`define RGC_OFF_ROOT_ADDR_LO 12'h020
`define RGC_OFF_ROOT_ADDR_HI 12'h024
`define RGC_OFF_COMMAND 12'h018
`define RGC_OFF_STATUS 12'h01c
`define RGC_OFF_FAULT_LOG_LO 12'h058
`define RGC_OFF_FAULT_LOG_HI 12'h05c
`define RGC_OFF_ROOT_LIVE_LO 12'h100
`define RGC_OFF_ROOT_LIVE_HI 12'h104
`define RGC_OFF_FLOG_LIVE_LO 12'h108
`define RGC_OFF_FLOG_LIVE_HI 12'h10c
`define RGC_BIT_TE 31
`define RGC_BIT_RTP 30
`define RGC_BIT_FL 29
`define RGC_BIT_AFL 28
`define RGC_ONE_SHOT_MASK 32'h96ffffff
`define RGC_RESET_WORD 32'h00000000
`define RGC_RESP_OKAY 2'b00
`define RGC_RESP_SLVERR 2'b10
`define RGC_LATCH_TIME_NS 20
`define RGC_LATCH_CYCLES ((`RGC_LATCH_TIME_NS + 9) / 10)
`endif

// ===== rgc_pkg.sv
// types shared by the global command block
package rgc_pkg;
  typedef enum logic [2:0] {
    RGC_IDLE = 3'b000,
    RGC_DRAIN = 3'b001,
    RGC_SWITCH = 3'b011,
    RGC_LATCH = 3'b010,
    RGC_DONE = 3'b110
  } rgc_state_t;

  typedef struct packed {
    logic te;
    logic rtp;
    logic fl;
    logic afl;
  } rgc_cmd_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rgc_wr_t;
endpackage

// ===== rgc_ptr_latch.sv
// 64-bit pointer pair: programmed copy and live copy loaded on command
`timescale 1ns/1ps
module rgc_ptr_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic load,
  output logic [63:0] programmed,
  output logic [63:0] live
);
  // byte-lane writes into the programmed copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      programmed <= 64'h0;
    else
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (wr_lo && wstrb[b])
          programmed[b*8 +: 8] <= wdata[b*8 +: 8];
        if (wr_hi && wstrb[b])
          programmed[32 + b*8 +: 8] <= wdata[b*8 +: 8];
      end
    end
  end

  // live copy only moves on load, so a half-written address is never used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      live <= 64'h0;
    else if (load)
      live <= programmed;
  end
endmodule

// ===== rgc_drain_wait.sv
// waits for the dma path to go idle before a translation switch
`timescale 1ns/1ps
module rgc_drain_wait (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic drain_supported,
  input wire logic dma_idle,
  output logic done
);
  logic waiting;

  // idle sample between transactions marks a clean boundary
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      waiting <= 1'b0;
    else if (start)
      waiting <= 1'b1;
    else if (done)
      waiting <= 1'b0;
  end

  // without drain support only the one-cycle wait remains, with dma_idle ignored
  assign done = waiting && (dma_idle || !drain_supported);
endmodule

// ===== rgc_global_command.sv
// global command register with status, pointer latches and axi4-lite slave
`timescale 1ns/1ps
`include "rgc_defines.svh"
module rgc_global_command (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adv_fault_log_supported,
  input wire logic drain_supported,
  input wire logic dma_idle,
  output logic translation_active,
  output logic fault_log_to_memory,
  output logic [63:0] root_pointer,
  output logic [63:0] fault_log_pointer
);
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  rgc_pkg::rgc_wr_t wr;
  logic [31:0] status_word;
  logic translation_enabled_status;
  logic root_pointer_status;
  logic fault_log_status;
  logic adv_fault_log_status;
  rgc_pkg::rgc_state_t state;
  rgc_pkg::rgc_state_t next_state;
  rgc_pkg::rgc_cmd_t pend;
  logic te_target;
  logic cmd_write;
  logic start_te;
  logic start_rtp;
  logic start_fl;
  logic start_afl;
  logic drain_start;
  logic drain_done;
  logic [7:0] latch_cnt;
  logic load_root;
  logic load_flog;
  logic [63:0] root_programmed;
  logic [63:0] flog_programmed;
  logic [31:0] rd_word;
  logic rd_hit;

  // write address and data are taken separately, in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 12'h0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  assign wr_fire = aw_held && w_held;
  assign wr = '{addr: {aw_addr[11:2], 2'b00}, data: w_data, strb: w_strb};

  // a command that arrives while another runs is refused with slverr
  assign cmd_write = wr_fire && (wr.addr == `RGC_OFF_COMMAND) && (state == rgc_pkg::RGC_IDLE) && wr.strb[3];

  always_comb
  begin
    wr_hit = 1'b0;
    case (wr.addr)
      `RGC_OFF_COMMAND: wr_hit = (state == rgc_pkg::RGC_IDLE);
      `RGC_OFF_ROOT_ADDR_LO, `RGC_OFF_ROOT_ADDR_HI: wr_hit = 1'b1;
      `RGC_OFF_FAULT_LOG_LO, `RGC_OFF_FAULT_LOG_HI: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response one cycle after both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RGC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // decode one command per write; priority picks the highest bit if software breaks serialisation
  always_comb
  begin
    start_te = 1'b0;
    start_rtp = 1'b0;
    start_fl = 1'b0;
    start_afl = 1'b0;
    if (cmd_write)
    begin
      if (wr.data[`RGC_BIT_TE] != translation_enabled_status)
        start_te = 1'b1;
      else if (wr.data[`RGC_BIT_RTP])
        start_rtp = 1'b1;
      else if (wr.data[`RGC_BIT_FL] && adv_fault_log_supported)
        start_fl = 1'b1;
      else if (adv_fault_log_supported && (wr.data[`RGC_BIT_AFL] != adv_fault_log_status))
        start_afl = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend <= '0;
      te_target <= 1'b0;
    end
    else if (cmd_write)
    begin
      pend <= '{te: start_te, rtp: start_rtp, fl: start_fl, afl: start_afl};
      te_target <= wr.data[`RGC_BIT_TE];
    end
  end

  // command sequencer; translation waits for a drain, latches take a fixed time
  always_comb
  begin
    next_state = state;
    case (state)
      rgc_pkg::RGC_IDLE:
      begin
        if (start_te)
          next_state = rgc_pkg::RGC_DRAIN;
        else if (start_rtp || start_fl || start_afl)
          next_state = rgc_pkg::RGC_LATCH;
      end
      rgc_pkg::RGC_DRAIN:
      begin
        if (drain_done)
          next_state = rgc_pkg::RGC_SWITCH;
      end
      rgc_pkg::RGC_SWITCH: next_state = rgc_pkg::RGC_DONE;
      rgc_pkg::RGC_LATCH:
      begin
        if (latch_cnt == 8'(`RGC_LATCH_CYCLES - 1))
          next_state = rgc_pkg::RGC_DONE;
      end
      rgc_pkg::RGC_DONE: next_state = rgc_pkg::RGC_IDLE;
      default: next_state = rgc_pkg::RGC_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= rgc_pkg::RGC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      latch_cnt <= 8'h0;
    else if (state == rgc_pkg::RGC_LATCH)
      latch_cnt <= latch_cnt + 8'h1;
    else
      latch_cnt <= 8'h0;
  end

  assign drain_start = (state == rgc_pkg::RGC_IDLE) && start_te;

  rgc_drain_wait u_drain (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(drain_start),
    .drain_supported(drain_supported),
    .dma_idle(dma_idle),
    .done(drain_done)
  );

  // translation flips in the switch cycle, after the drain found a clean boundary
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      translation_active <= 1'b0;
    else if (state == rgc_pkg::RGC_SWITCH)
      translation_active <= te_target;
  end

  // translation and advanced log status bits update only when the operation completes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      translation_enabled_status <= 1'b0;
    else if (state == rgc_pkg::RGC_DONE && pend.te)
      translation_enabled_status <= te_target;
  end

  // one-shot status: cleared as the latch starts, set when done
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      root_pointer_status <= 1'b0;
    else if (state == rgc_pkg::RGC_DONE && pend.rtp)
      root_pointer_status <= 1'b1;
    else if (start_rtp)
      root_pointer_status <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_log_status <= 1'b0;
    else if (state == rgc_pkg::RGC_DONE && pend.fl)
      fault_log_status <= 1'b1;
    else if (start_fl)
      fault_log_status <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      adv_fault_log_status <= 1'b0;
    else if (state == rgc_pkg::RGC_DONE && pend.afl)
      adv_fault_log_status <= !adv_fault_log_status;
  end

  assign fault_log_to_memory = adv_fault_log_status;

  // pointer loads happen at completion; log load is allowed with translation on
  assign load_root = (state == rgc_pkg::RGC_DONE) && pend.rtp;
  assign load_flog = (state == rgc_pkg::RGC_DONE) && pend.fl;

  rgc_ptr_latch u_root (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_lo(wr_fire && wr.addr == `RGC_OFF_ROOT_ADDR_LO),
    .wr_hi(wr_fire && wr.addr == `RGC_OFF_ROOT_ADDR_HI),
    .wdata(wr.data),
    .wstrb(wr.strb),
    .load(load_root),
    .programmed(root_programmed),
    .live(root_pointer)
  );

  rgc_ptr_latch u_flog (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_lo(wr_fire && wr.addr == `RGC_OFF_FAULT_LOG_LO),
    .wr_hi(wr_fire && wr.addr == `RGC_OFF_FAULT_LOG_HI),
    .wdata(wr.data),
    .wstrb(wr.strb),
    .load(load_flog),
    .programmed(flog_programmed),
    .live(fault_log_pointer)
  );

  assign status_word = {translation_enabled_status, root_pointer_status, fault_log_status,
                        adv_fault_log_status, 28'h0};

  // read mux; the command register reads as zero since its value is meaningless
  always_comb
  begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[11:2], 2'b00})
      `RGC_OFF_COMMAND: rd_word = 32'h0;
      `RGC_OFF_STATUS: rd_word = status_word;
      `RGC_OFF_ROOT_ADDR_LO: rd_word = root_programmed[31:0];
      `RGC_OFF_ROOT_ADDR_HI: rd_word = root_programmed[63:32];
      `RGC_OFF_FAULT_LOG_LO: rd_word = flog_programmed[31:0];
      `RGC_OFF_FAULT_LOG_HI: rd_word = flog_programmed[63:32];
      `RGC_OFF_ROOT_LIVE_LO: rd_word = root_pointer[31:0];
      `RGC_OFF_ROOT_LIVE_HI: rd_word = root_pointer[63:32];
      `RGC_OFF_FLOG_LIVE_LO: rd_word = fault_log_pointer[31:0];
      `RGC_OFF_FLOG_LIVE_HI: rd_word = fault_log_pointer[63:32];
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read data registered one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RGC_RESET_WORD;
      s_axi_rresp <= `RGC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `RGC_RESP_OKAY : `RGC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// ===== rgc_global_command_properties.sv
// port assertions for the global command block
`timescale 1ns/1ps
module rgc_global_command_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic adv_fault_log_supported,
  input wire logic drain_supported,
  input wire logic dma_idle,
  input wire logic translation_active,
  input wire logic fault_log_to_memory,
  input wire logic [63:0] root_pointer,
  input wire logic [63:0] fault_log_pointer
);
  // cycles since a root latch one was written; saturates so stale writes expire
  logic [3:0] age;
  always_ff @(posedge aclk)
    if (!aresetn)
      age <= 4'hf;
    else if (s_axi_wvalid && s_axi_wready && s_axi_wdata[30] && s_axi_wstrb[3])
      age <= 4'h0;
    else if (age != 4'hf)
      age <= age + 4'h1;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // both write halves taken at one edge
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_bresp_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_write_answer:
    assert property (s_wr |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_switch_at_idle:
    assert property (drain_supported && $changed(translation_active) |-> $past(dma_idle) || $past(dma_idle, 2))
    else $error("translation switched with dma in flight");
  a_log_bits_inert:
    assert property (!adv_fault_log_supported |=> $stable(fault_log_to_memory) && $stable(fault_log_pointer))
    else $error("log command acted without support");
  a_root_needs_cmd:
    assert property ($changed(root_pointer) |-> age < 4'h8)
    else $error("root pointer moved without latch command");
endmodule

bind rgc_global_command rgc_global_command_properties chk_i (.*);

// ===== rgc_global_command_test.sv
// self-checking bench for the global command block
`timescale 1ns/1ps
module rgc_global_command_test;
  localparam logic [1:0] ok = 2'b00;
  localparam logic [1:0] err = 2'b10;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, translation_active, fault_log_to_memory;
  logic adv_fault_log_supported, drain_supported, dma_idle;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [63:0] root_pointer, fault_log_pointer, ra, fa;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int fails = 0;
  int samples_checked = 0;

  rgc_global_command uut (.*);

  // free-running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait for a handshake; a hang ends the run
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s !== 1'b1 && n < 200);
    if (s !== 1'b1)
    begin
      $display("CHECK FAILED %0t: handshake timeout", $time);
      fails++;
      stop_test();
    end
  endtask

  // at least one edge of stall so a ready never gets two values in one step
  task automatic stall();
    repeat (1 + lfsr() % 3) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    wait_hi(s_axi_awready);
    s_axi_awvalid <= 1'b0;
    if (s_axi_wready !== 1'b1)
      wait_hi(s_axi_wready);
    s_axi_wvalid <= 1'b0;
    stall();
    s_axi_bready <= 1'b1;
    wait_hi(s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    wait_hi(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    stall();
    s_axi_rready <= 1'b1;
    wait_hi(s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // responses are matched against the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      chk(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // main sequence
  initial
  begin
    seed = 32'h87c3;
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    adv_fault_log_supported = 1'b0;
    drain_supported = 1'b1;
    dma_idle = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h01c, 32'h0, ok);
    ra = {lfsr(), lfsr()};
    wr(12'h020, ra[31:0], ok);
    wr(12'h024, ra[63:32], ok);
    wr(12'h018, 32'h0, ok);
    repeat (20) @(posedge aclk);
    chk(root_pointer, 64'h0);
    wr(12'h018, 32'h40000000, ok);
    repeat (20) @(posedge aclk);
    chk(root_pointer, ra);
    rd(12'h01c, 32'h40000000, ok);
    rd(12'h100, ra[31:0], ok);
    rd(12'h018, 32'h0, ok);
    // enable held off by busy dma, second command refused meanwhile
    wr(12'h018, 32'h80000000, ok);
    wr(12'h018, 32'h40000000, err);
    repeat (20) @(posedge aclk);
    chk(translation_active, 64'h0);
    dma_idle <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(translation_active, 64'h1);
    rd(12'h01c, 32'hc0000000, ok);
    // same root relatched while remapping is on; masked status plus the latch bit
    wr(12'h018, 32'hc0000000, ok);
    repeat (20) @(posedge aclk);
    chk(root_pointer, ra);
    chk(translation_active, 64'h1);
    // log pointer swap while remapping stays on
    adv_fault_log_supported <= 1'b1;
    fa = {lfsr(), lfsr()};
    wr(12'h058, fa[31:0], ok);
    wr(12'h05c, fa[63:32], ok);
    wr(12'h018, 32'ha0000000, ok);
    repeat (20) @(posedge aclk);
    chk(fault_log_pointer, fa);
    chk(translation_active, 64'h1);
    rd(12'h01c, 32'he0000000, ok);
    wr(12'h018, 32'h90000000, ok);
    repeat (20) @(posedge aclk);
    chk(fault_log_to_memory, 64'h1);
    wr(12'h018, 32'h80000000, ok);
    repeat (20) @(posedge aclk);
    chk(fault_log_to_memory, 64'h0);
    // without support both log bits must do nothing
    adv_fault_log_supported <= 1'b0;
    wr(12'h058, ~fa[31:0], ok);
    wr(12'h018, 32'ha0000000, ok);
    wr(12'h018, 32'h90000000, ok);
    repeat (20) @(posedge aclk);
    chk(fault_log_pointer, fa);
    chk(fault_log_to_memory, 64'h0);
    // disable with no draining and noisy dma activity
    drain_supported <= 1'b0;
    wr(12'h018, 32'h0, ok);
    repeat (20) @(posedge aclk) dma_idle <= lfsr() > 32'h7fffffff;
    chk(translation_active, 64'h0);
    rd(12'h01c, 32'h60000000, ok);
    // a command write without the top byte lane is accepted but does nothing
    s_axi_wstrb <= 4'h7;
    wr(12'h018, 32'h80000000, ok);
    repeat (20) @(posedge aclk);
    chk(translation_active, 64'h0);
    s_axi_wstrb <= 4'hf;
    wr(12'h200, lfsr(), err);
    rd(12'h200, 32'h0, err);
    for (int i = 0; i < 4; i++)
    begin
      ra[31:0] = lfsr();
      wr(12'h020, ra[31:0], ok);
      rd(12'h020, ra[31:0], ok);
    end
    repeat (2) @(posedge aclk);
    chk(bq.size() + rq.size(), 64'h0);
    stop_test();
  end
endmodule
